// ### rtl/plsr_top.sv
// Purpose: link status and fast link drop cause registers over AXI4-Lite
// Assumes: event inputs are one-cycle pulses synchronous to aclk
// Notes:   reads that clear bits act at the read address handshake
//          so the word returned still shows the bit as it was
//          a new event in the clearing cycle is kept: set beats clear
//          lower status bits are held at their reset pattern
//
// What this block does
// - each enabled cause that drops the link sets its bit; field clears on read
// - cause bits: energy loss, low SNR, MLT3 errors, rx errors, descrambler sync
// - a cause latches only when its detection mode is enabled
// - link drop is the OR of causes enabled by config bit 10 and bits 3:0
// - phy status register sits at index 0x10 and resets to 0x6
// - bit 14 reads 1 when crossover swapped the pairs, else 0
// - bit 13 latches receive errors, cleared by reading the rx error counter
// - bit 12 mirrors inverted polarity, cleared by ten meg register read or reset
// - bit 11 latches false carrier, cleared by reading false carrier counter
// - bit 10 shows the 100 Mbps signal detect indication
// - bit 9 shows the 100 Mbps descrambler lock indication
// - bit 8 mirrors page received, cleared by autoneg expansion read
// - bit 7 shows pending internal interrupt, cleared by interrupt source read
// - bit 6 latches remote fault, cleared by basic mode status read or reset
module plsr_top
   import plsr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [4:0]        fld_condition,
   input  wire logic              mdix_swapped,
   input  wire logic              rx_error_event,
   input  wire logic              polarity_inverted_event,
   input  wire logic              false_carrier_event,
   input  wire logic              signal_detect,
   input  wire logic              descrambler_lock,
   input  wire logic              page_received_event,
   input  wire logic              internal_int_event,
   input  wire logic              remote_fault_event,
   output logic                   link_drop,
   output logic                   irq
);

   // write channel holding state
   logic              aw_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic              w_held_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;

   // read channel state
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;

   // register state
   logic [15:0]          fld_cfg_q;
   logic [FLD_CAUSES-1:0] fld_cause_q;
   logic                 mdix_q;
   logic                 rx_err_q;
   logic                 polarity_q;
   logic                 false_car_q;
   logic                 sig_det_q;
   logic                 descr_lock_q;
   logic                 page_rx_q;
   logic                 int_pend_q;
   logic                 remote_q;
   logic [IRQ_W-1:0]     irq_status_q;
   logic [IRQ_W-1:0]     irq_mask_q;

   // decoded strobes
   logic              wr_fire;
   logic              rd_fire;
   logic [7:0]        wr_idx;
   logic [7:0]        rd_idx;
   logic              wr_aligned;
   logic              rd_aligned;
   logic [FLD_CAUSES-1:0] fld_enable;
   logic [FLD_CAUSES-1:0] fld_hit;
   logic [IRQ_W-1:0]  irq_events;
   logic [15:0]       phy_status_word;
   logic [31:0]       rd_word;
   logic              rd_mapped;

   // clear-on-read strobes, one per register read
   logic rd_fld_cause;
   logic rd_basic_mode;
   logic rd_autoneg;
   logic rd_int_src;
   logic rd_false_car;
   logic rd_rx_err;
   logic rd_ten_meg;
   logic rd_irq_status;

   // bus handshakes: accept each write channel once, hold until response leaves
   // holding both write channels while a response waits keeps one write
   // in flight; the read side answers one cycle after its address
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign wr_fire    = aw_held_q && w_held_q && !bvalid_q;
   assign rd_fire    = s_axi_arvalid && s_axi_arready;
   assign wr_idx     = 8'(aw_addr_q >> 2);
   assign rd_idx     = 8'(s_axi_araddr >> 2);
   // upper address bits beyond the index must be zero for a hit
   // aliasing is avoided at the cost of a wider compare
   assign wr_aligned = ((aw_addr_q >> 10) == '0);
   assign rd_aligned = ((s_axi_araddr >> 10) == '0);

   // write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   // write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   // write response; writes to read-only indices are ignored but answered okay
   // a decode error changes nothing; the response only reports the miss
   // the response waits for bready and both write channels stay closed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_aligned && rd_map(wr_idx)) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // indices that answer okay; must list the same places as the read mux
   // or writes and reads would disagree on what is mapped
   function automatic logic rd_map(input logic [7:0] idx);
      case (idx)
         IDX_BASIC_MODE_STATUS, IDX_AUTONEG_EXPANSION, IDX_FLD_CONFIG,
         IDX_FLD_CAUSE, IDX_PHY_STATUS, IDX_INTERRUPT_SOURCE,
         IDX_FALSE_CARRIER_CNT, IDX_RX_ERROR_CNT, IDX_TEN_MEG_STATUS,
         IDX_IRQ_STATUS, IDX_IRQ_MASK: rd_map = 1'b1;
         default: rd_map = 1'b0;
      endcase
   endfunction

   // fast link drop configuration, byte lanes honoured
   // only bits 10 and 3:0 act; the rest is plain storage read back as written
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fld_cfg_q <= FLD_CONFIG_RESET;
      end else if (wr_fire && wr_aligned && wr_idx == IDX_FLD_CONFIG) begin
         if (w_strb_q[0]) fld_cfg_q[7:0]  <= w_data_q[7:0];
         if (w_strb_q[1]) fld_cfg_q[15:8] <= w_data_q[15:8];
      end
   end

   // interrupt mask, same layout as interrupt status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_q <= IRQ_MASK_RESET[IRQ_W-1:0];
      end else if (wr_fire && wr_aligned && wr_idx == IDX_IRQ_MASK) begin
         if (w_strb_q[0]) irq_mask_q[7:0] <= w_data_q[7:0];
         if (w_strb_q[1]) irq_mask_q[8]   <= w_data_q[8];
      end
   end

   // read strobes that clear latched bits
   assign rd_fld_cause  = rd_fire && rd_aligned && rd_idx == IDX_FLD_CAUSE;
   assign rd_basic_mode = rd_fire && rd_aligned && rd_idx == IDX_BASIC_MODE_STATUS;
   assign rd_autoneg    = rd_fire && rd_aligned && rd_idx == IDX_AUTONEG_EXPANSION;
   assign rd_int_src    = rd_fire && rd_aligned && rd_idx == IDX_INTERRUPT_SOURCE;
   assign rd_false_car  = rd_fire && rd_aligned && rd_idx == IDX_FALSE_CARRIER_CNT;
   assign rd_rx_err     = rd_fire && rd_aligned && rd_idx == IDX_RX_ERROR_CNT;
   assign rd_ten_meg    = rd_fire && rd_aligned && rd_idx == IDX_TEN_MEG_STATUS;
   assign rd_irq_status = rd_fire && rd_aligned && rd_idx == IDX_IRQ_STATUS;

   // cause enables: bits 3:0 map to causes 0..3, bit 10 to descrambler sync
   assign fld_enable = {fld_cfg_q[FLD_CFG_HI], fld_cfg_q[FLD_CFG_LO_W-1:0]};
   assign fld_hit    = fld_condition & fld_enable;
   assign link_drop  = |fld_hit;

   // cause latches; a new hit beats the clearing read
   // a condition held high keeps re-setting its bit, so a clear only
   // sticks once the cause has gone away
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fld_cause_q <= '0;
      end else begin
         fld_cause_q <= (fld_cause_q & {FLD_CAUSES{!rd_fld_cause}}) | fld_hit;
      end
   end

   // live mirrors, registered so the read word comes from flops
   // one cycle of lag on these levels; no stretching, so a short glitch
   // on an indication can be missed by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mdix_q       <= 1'b0;
         sig_det_q    <= 1'b0;
         descr_lock_q <= 1'b0;
      end else begin
         mdix_q       <= mdix_swapped;
         sig_det_q    <= signal_detect;
         descr_lock_q <= descrambler_lock;
      end
   end

   // latched status bits, each cleared by its own source register read
   // reading the summary itself never clears them, so several readers
   // of the summary do not race each other for an event
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_err_q    <= 1'b0;
         polarity_q  <= 1'b0;
         false_car_q <= 1'b0;
         page_rx_q   <= 1'b0;
         int_pend_q  <= 1'b0;
         remote_q    <= 1'b0;
      end else begin
         rx_err_q    <= (rx_err_q && !rd_rx_err) || rx_error_event;
         polarity_q  <= (polarity_q && !rd_ten_meg) || polarity_inverted_event;
         false_car_q <= (false_car_q && !rd_false_car) || false_carrier_event;
         page_rx_q   <= (page_rx_q && !rd_autoneg) || page_received_event;
         int_pend_q  <= (int_pend_q && !rd_int_src) || internal_int_event;
         remote_q    <= (remote_q && !rd_basic_mode) || remote_fault_event;
      end
   end

   // block interrupt: sticky events, read clears, new event wins
   // internal interrupt and polarity stay out of the sticky set;
   // they already have clearing reads of their own
   assign irq_events = {remote_fault_event, page_received_event,
                        false_carrier_event, rx_error_event, fld_hit};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (irq_status_q & {IRQ_W{!rd_irq_status}}) | irq_events;
      end
   end
   assign irq = |(irq_status_q & irq_mask_q);

   // phy status word; lower bits stay at their reset pattern here
   // the live lower bits belong to logic outside this block
   always_comb begin
      phy_status_word                   = PHY_STATUS_RESET;
      phy_status_word[PS_MDIX]          = mdix_q;
      phy_status_word[PS_RX_ERR]        = rx_err_q;
      phy_status_word[PS_POLARITY]      = polarity_q;
      phy_status_word[PS_FALSE_CARR]    = false_car_q;
      phy_status_word[PS_SIG_DETECT]    = sig_det_q;
      phy_status_word[PS_DESCR_LOCK]    = descr_lock_q;
      phy_status_word[PS_PAGE_RX]       = page_rx_q;
      phy_status_word[PS_INT_PEND]      = int_pend_q;
      phy_status_word[PS_REMOTE_FLT]    = remote_q;
   end

   // read mux; outside registers show only the bits mirrored here
   // counter registers read zero here; their counts live elsewhere
   always_comb begin
      rd_word   = '0;
      rd_mapped = rd_aligned;
      case (rd_idx)
         IDX_PHY_STATUS:        rd_word[15:0] = phy_status_word;
         IDX_FLD_CAUSE:         rd_word[FLD_CAUSE_LSB +: FLD_CAUSES] = fld_cause_q;
         IDX_FLD_CONFIG:        rd_word[15:0] = fld_cfg_q;
         IDX_TEN_MEG_STATUS:    rd_word[TEN_MEG_POLARITY_BIT] = polarity_q;
         IDX_AUTONEG_EXPANSION: rd_word[AUTONEG_PAGE_BIT] = page_rx_q;
         IDX_IRQ_STATUS:        rd_word[IRQ_W-1:0] = irq_status_q;
         IDX_IRQ_MASK:          rd_word[IRQ_W-1:0] = irq_mask_q;
         IDX_BASIC_MODE_STATUS, IDX_INTERRUPT_SOURCE,
         IDX_FALSE_CARRIER_CNT, IDX_RX_ERROR_CNT: rd_word = '0;
         default:               rd_mapped = 1'b0;
      endcase
      if (!rd_mapped) begin
         rd_word = '0;
      end
   end

   // read data registered at the address handshake
   // clearing reads take effect at this same edge, so the word returned
   // is the one from before the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule // plsr_top

// ### rtl/plsr_pkg.sv
// Purpose: constants for the link status register block
// Assumes: register index times four is the AXI byte address
// Notes:   index values follow the management register numbering
package plsr_pkg;
   // register indices (management numbering)
   localparam logic [7:0] IDX_BASIC_MODE_STATUS  = 8'h01;
   localparam logic [7:0] IDX_AUTONEG_EXPANSION  = 8'h06;
   localparam logic [7:0] IDX_FLD_CONFIG         = 8'h0B;
   localparam logic [7:0] IDX_FLD_CAUSE          = 8'h0F;
   localparam logic [7:0] IDX_PHY_STATUS         = 8'h10;
   localparam logic [7:0] IDX_INTERRUPT_SOURCE   = 8'h12;
   localparam logic [7:0] IDX_FALSE_CARRIER_CNT  = 8'h14;
   localparam logic [7:0] IDX_RX_ERROR_CNT       = 8'h15;
   localparam logic [7:0] IDX_TEN_MEG_STATUS     = 8'h1A;
   localparam logic [7:0] IDX_IRQ_STATUS         = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK           = 8'h21;

   // reset values
   localparam logic [15:0] PHY_STATUS_RESET = 16'h0006;
   localparam logic [15:0] FLD_CONFIG_RESET = 16'h0000;
   localparam logic [15:0] IRQ_MASK_RESET   = 16'h0000;

   // fast link drop field
   localparam int FLD_CAUSES    = 5;
   localparam int FLD_CAUSE_LSB = 4;
   localparam int FLD_CFG_HI    = 10; // descrambler cause enable
   localparam int FLD_CFG_LO_W  = 4;  // causes 0..3 enables at [3:0]

   // phy status bit positions
   localparam int PS_MDIX        = 14;
   localparam int PS_RX_ERR      = 13;
   localparam int PS_POLARITY    = 12;
   localparam int PS_FALSE_CARR  = 11;
   localparam int PS_SIG_DETECT  = 10;
   localparam int PS_DESCR_LOCK  = 9;
   localparam int PS_PAGE_RX     = 8;
   localparam int PS_INT_PEND    = 7;
   localparam int PS_REMOTE_FLT  = 6;
   localparam int PS_LOWER_W     = 6;

   // mirrored bit positions in the source registers
   localparam int TEN_MEG_POLARITY_BIT = 4;
   localparam int AUTONEG_PAGE_BIT     = 1;

   // interrupt status layout: fld causes [4:0], then these
   localparam int IRQ_W         = 9;
   localparam int IRQ_RX_ERR    = 5;
   localparam int IRQ_FALSE_CAR = 6;
   localparam int IRQ_PAGE_RX   = 7;
   localparam int IRQ_REMOTE    = 8;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

// ### test/plsr_asserts.sv
// Purpose: bus and status checks on the link status register block
// Assumes: single clock, synchronous active-low reset
// Notes:   sees only top-level ports; bound below
module plsr_asserts
   import plsr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [4:0]        fld_condition,
   input wire logic              link_drop,
   input wire logic              irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // read answers one cycle after the address is taken
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_rd_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_drop_cause: assert property (link_drop |-> |fld_condition)
      else $error("link drop without condition");
   // reserved and lower bits of the status summary never move
   a_phy_fixed: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == ADDR_W'({IDX_PHY_STATUS, 2'b00}) |=>
      s_axi_rdata[31:15] == 17'h0_0000 && s_axi_rdata[5:0] == 6'h06)
      else $error("status summary fixed bits wrong");
   // reset must be seen even though other checks are disabled during it
   a_reset_idle: assert property (disable iff (1'b0)
      !aresetn |=> !s_axi_rvalid && !s_axi_bvalid && !irq)
      else $error("outputs busy after reset");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_drop: cover property (link_drop);
   c_irq: cover property ($rose(irq));
endmodule // plsr_asserts

bind plsr_top plsr_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### test/phy_link_status_regs_bench.sv
// Purpose: self-checking bench for the link status register block
// Assumes: AXI4-Lite master in this bench, 125 MHz clock
// Notes:   handshakes judged at the falling edge, driven after rising
module phy_link_status_regs_bench
   import plsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic        arvalid = 0, rready = 0, mdix = 0, sd = 0, lk = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [4:0]  cond = 0;
   logic [5:0]  ev = 0;
   logic        awready, wready, bvalid, arready, rvalid, link_drop, irq;
   logic [1:0]  bresp, rresp, rr;
   logic [31:0] rdata;
   int          fail_count = 0, n_checks = 0;

   always #4 aclk = ~aclk;

   plsr_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fld_condition(cond), .mdix_swapped(mdix), .rx_error_event(ev[0]),
      .polarity_inverted_event(ev[1]), .false_carrier_event(ev[2]),
      .signal_detect(sd), .descrambler_lock(lk), .page_received_event(ev[3]),
      .internal_int_event(ev[4]), .remote_fault_event(ev[5]),
      .link_drop(link_drop), .irq(irq));

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // a hung handshake counts as a mismatch and ends the run
   task automatic hang(input logic done);
      if (!done) begin
         fail_count++;
         summarize();
      end
   endtask

   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction

   // expected summary: latched bits plus level copies and fixed low bits
   function automatic logic [31:0] phy(input logic [15:0] l);
      return {16'h0000, l | PHY_STATUS_RESET | (16'(mdix) << PS_MDIX)
              | (16'(sd) << PS_SIG_DETECT) | (16'(lk) << PS_DESCR_LOCK)};
   endfunction

   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rsp);
      int   t;
      logic hw, hd, hb;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      hb = 0;
      for (t = 0; t < 60 && !hb; t++) begin
         @(negedge aclk);
         hw = awvalid && awready;
         hd = wvalid && wready;
         hb = bvalid && bready;
         rsp = bresp;
         @(posedge aclk);
         if (hw) awvalid <= 1'h0;
         if (hd) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      hang(hb);
      @(posedge aclk); // an edge passes before the next request
   endtask

   // pm pulses events on the same edge that takes the read address
   task automatic rd(input logic [11:0] a, input logic [5:0] pm, output logic [31:0] d);
      int   t;
      logic ha, hr;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      ev <= pm;
      hr = 0;
      for (t = 0; t < 60 && !hr; t++) begin
         @(negedge aclk);
         ha = arvalid && arready;
         hr = rvalid && rready;
         d = {rdata[31:2], rdata[1:0]};
         rr = rresp;
         @(posedge aclk);
         ev <= 6'h00;
         if (ha) arvalid <= 1'h0;
      end
      rready <= 1'h0;
      hang(hr);
      @(posedge aclk); // an edge passes before the next request
   endtask

   task automatic pulse(input logic [5:0] m);
      ev <= m;
      @(posedge aclk);
      ev <= 6'h00;
      @(posedge aclk);
   endtask

   initial begin
      logic [31:0] d, m;
      logic [1:0]  r;
      logic [4:0]  en, c;
      int          i;
      int          bits[6];
      logic [7:0]  clr[6];
      void'($urandom(32'h59c3_80b7));
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(ba(IDX_PHY_STATUS), 6'h00, d);
      chk("phy_reset", d, 32'h0000_0006);
      chk("rd_okay", rr, RESP_OKAY);
      chk("irq_reset", irq, 1'h0);
      // unmapped place and read-only write
      wr(12'hFFC, $urandom, r);
      chk("wr_decerr", r, RESP_DECERR);
      rd(12'hFFC, 6'h00, d);
      chk("rd_unmapped", d, 32'h0000_0000);
      chk("rd_decerr", rr, RESP_DECERR);
      wr(ba(IDX_PHY_STATUS), $urandom, r);
      chk("wr_ro_okay", r, RESP_OKAY);
      rd(ba(IDX_PHY_STATUS), 6'h00, d);
      chk("phy_ro", d, 32'h0000_0006);
      $display("test bus done");
      // drop causes: all enabled, none enabled, then random mixes
      for (i = 0; i < 8; i++) begin
         en = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : 5'($urandom);
         c = (i == 0) ? 5'h10 : (i == 1) ? 5'h1F : 5'($urandom);
         wr(ba(IDX_FLD_CONFIG), 32'({en[4], 6'h00, en[3:0]}), r);
         cond <= c;
         @(negedge aclk);
         chk("link_drop", link_drop, |(c & en));
         @(posedge aclk);
         cond <= 5'h00;
         @(posedge aclk);
         rd(ba(IDX_FLD_CAUSE), 6'h00, d);
         chk("fld_cause", d, 32'(c & en) << FLD_CAUSE_LSB);
         rd(ba(IDX_FLD_CAUSE), 6'h00, d);
         chk("fld_cleared", d, 32'h0000_0000);
      end
      $display("test fld done");
      bits = '{PS_RX_ERR, PS_POLARITY, PS_FALSE_CARR, PS_PAGE_RX, PS_INT_PEND, PS_REMOTE_FLT};
      clr = '{IDX_RX_ERROR_CNT, IDX_TEN_MEG_STATUS, IDX_FALSE_CARRIER_CNT,
              IDX_AUTONEG_EXPANSION, IDX_INTERRUPT_SOURCE, IDX_BASIC_MODE_STATUS};
      // each latch: set, survive a summary read, survive a racing clear, clear
      for (i = 0; i < 6; i++) begin
         mdix <= 1'($urandom);
         sd <= 1'($urandom);
         lk <= 1'($urandom);
         pulse(6'h01 << i);
         rd(ba(IDX_PHY_STATUS), 6'h00, d);
         chk("phy_set", d, phy(16'h0001 << bits[i]));
         rd(ba(IDX_PHY_STATUS), 6'h00, d);
         chk("phy_kept", d, phy(16'h0001 << bits[i]));
         rd(ba(clr[i]), 6'h01 << i, d);
         m = (i == 1) ? 32'h0000_0001 << TEN_MEG_POLARITY_BIT :
             (i == 3) ? 32'h0000_0001 << AUTONEG_PAGE_BIT : 32'h0000_0000;
         chk("src_mirror", d, m);
         rd(ba(IDX_PHY_STATUS), 6'h00, d);
         chk("phy_race", d, phy(16'h0001 << bits[i]));
         rd(ba(clr[i]), 6'h00, d);
         rd(ba(IDX_PHY_STATUS), 6'h00, d);
         chk("phy_clear", d, phy(16'h0000));
      end
      $display("test events done");
      // interrupt: masked source stays quiet, unmasked raises, read clears
      rd(ba(IDX_IRQ_STATUS), 6'h00, d);
      wr(ba(IDX_IRQ_MASK), 32'h0000_0001 << IRQ_RX_ERR, r);
      pulse(6'h04);
      @(negedge aclk);
      chk("irq_masked", irq, 1'h0);
      @(posedge aclk);
      pulse(6'h01);
      @(negedge aclk);
      chk("irq_raised", irq, 1'h1);
      @(posedge aclk);
      rd(ba(IDX_IRQ_STATUS), 6'h00, d);
      chk("irq_status", d, (32'h0000_0001 << IRQ_RX_ERR) | (32'h0000_0001 << IRQ_FALSE_CAR));
      @(negedge aclk);
      chk("irq_cleared", irq, 1'h0);
      @(posedge aclk);
      $display("test irq done");
      summarize();
   end
endmodule // phy_link_status_regs_bench
